// *** logic/mcctb_consts.svh ***
// Offsets, fields, reset values and counts of the clock/time-base unit.
// Assumes an APB slave with 32-bit data and a 50 MHz pclk.
`ifndef MCCTB_CONSTS_SVH
`define MCCTB_CONSTS_SVH
// Register indices and byte addresses
`define MCCTB_IDX_CTRL_STATUS 8'h2c
`define MCCTB_IDX_BEEP_ADC 8'h2d
`define MCCTB_ADDR_CTRL_STATUS 12'h0b0
`define MCCTB_ADDR_BEEP_ADC 12'h0b4
`define MCCTB_RESET_VAL 8'h00
// Control/status fields
`define MCCTB_BIT_CLKOUT 7
`define MCCTB_BIT_SLOW 4
`define MCCTB_BIT_TBIE 1
`define MCCTB_BIT_TBF 0
// Beep/converter fields
`define MCCTB_BIT_STRETCH 3
`define MCCTB_BIT_ADC_IRQ 2
// Time-base periods in osc-derived clock cycles
`define MCCTB_TB_P0 18'd16000
`define MCCTB_TB_P1 18'd32000
`define MCCTB_TB_P2 18'd80000
`define MCCTB_TB_P3 18'd200000
// Beeper half periods (full tone of 4000, 8000, 16000 cycles)
`define MCCTB_BEEP_H1 14'd2000
`define MCCTB_BEEP_H2 14'd4000
`define MCCTB_BEEP_H3 14'd8000
`endif

// *** logic/mcctb_pkg.sv ***
// Types shared by the clock/time-base unit.
// Assumes nothing beyond the constants header.
package mcctb_pkg;
   typedef enum logic [1:0] {
      MCCTB_RUN,
      MCCTB_ACTIVE_HALT,
      MCCTB_HALT
   } mcctb_mode_t;
endpackage

// *** logic/mcctb_top.sv ***
// Main clock control unit: CPU prescaler, clock out, time base, beeper.
// Assumes pclk is the oscillator-derived clock and APB is synchronous.
`include "mcctb_consts.svh"

module mcctb_top
   import mcctb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_exec,
   input wire logic wake_irq,
   output logic cpu_tick,
   output logic clock_out_pin,
   output logic clock_out_pin_oe,
   output logic beeper_pin,
   output logic beeper_pin_oe,
   output logic timebase_irq,
   output logic adc_sample_stretch,
   output logic adc_irq_enable,
   output logic [1:0] power_mode
);

   // Register fields
   logic clock_out_enable_q;
   logic [1:0] cpu_prescale_sel_q;
   logic slow_select_q;
   logic [1:0] timebase_sel_q;
   logic timebase_irq_enable_q;
   logic timebase_flag_q;
   logic [3:0] beep_ctrl_q;
   mcctb_mode_t mode_q;

   // Internal state
   logic [1:0] tb_active_q;
   logic [17:0] tb_cnt_q;
   logic tb_end;
   logic [3:0] pre_cnt_q;
   logic clk_div_q;
   logic [13:0] beep_cnt_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic access_done;
   logic wr_ok;
   logic rd_csr;
   logic sel_csr;
   logic sel_bcr;

   // Period length of a time-base selection
   function automatic logic [17:0] tb_period(input logic [1:0] sel);
      case (sel)
         2'h0: tb_period = `MCCTB_TB_P0;
         2'h1: tb_period = `MCCTB_TB_P1;
         2'h2: tb_period = `MCCTB_TB_P2;
         default: tb_period = `MCCTB_TB_P3;
      endcase
   endfunction

   // Beeper half period of a beep selection
   function automatic logic [13:0] beep_half(input logic [1:0] sel);
      case (sel)
         2'h1: beep_half = `MCCTB_BEEP_H1;
         2'h2: beep_half = `MCCTB_BEEP_H2;
         default: beep_half = `MCCTB_BEEP_H3;
      endcase
   endfunction

   // Control/status register image
   function automatic logic [7:0] csr_image(input logic [7:0] unused);
      csr_image = {clock_out_enable_q, cpu_prescale_sel_q, slow_select_q,
         timebase_sel_q, timebase_irq_enable_q, timebase_flag_q} | unused;
   endfunction

   // APB decode; accesses finish one cycle into the access phase
   assign sel_csr = (paddr == `MCCTB_ADDR_CTRL_STATUS);
   assign sel_bcr = (paddr == `MCCTB_ADDR_BEEP_ADC);
   assign access_done = psel & penable & pready_q;
   assign wr_ok = access_done & pwrite & (mode_q == MCCTB_RUN);
   assign rd_csr = access_done & ~pwrite & sel_csr
      & (mode_q == MCCTB_RUN);
   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q & pready_q;

   // Bus handshake and read data capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= psel & penable & ~pready_q;
         if (psel & ~penable)
         begin
            pslverr_q <= ~(sel_csr | sel_bcr);
            if (pwrite)
               prdata_q <= 32'h0000_0000;
            else if (sel_csr)
               prdata_q <= {24'h00_0000, csr_image(8'h00)};
            else if (sel_bcr)
               prdata_q <= {28'h000_0000, beep_ctrl_q};
            else
               prdata_q <= 32'h0000_0000;
         end
      end
   end

   // Control/status writable fields, frozen outside run mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_out_enable_q <= 1'b0;
         cpu_prescale_sel_q <= 2'h0;
         slow_select_q <= 1'b0;
         timebase_sel_q <= 2'h0;
         timebase_irq_enable_q <= 1'b0;
      end
      else if (wr_ok & sel_csr)
      begin
         clock_out_enable_q <= pwdata[`MCCTB_BIT_CLKOUT];
         cpu_prescale_sel_q <= pwdata[6:5];
         slow_select_q <= pwdata[`MCCTB_BIT_SLOW];
         timebase_sel_q <= pwdata[3:2];
         timebase_irq_enable_q <= pwdata[`MCCTB_BIT_TBIE];
      end
   end

   // Beep/converter register; upper bits are not stored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         beep_ctrl_q <= 4'h0;
      else if (wr_ok & sel_bcr)
         beep_ctrl_q <= pwdata[3:0];
   end

   assign adc_sample_stretch = beep_ctrl_q[`MCCTB_BIT_STRETCH];
   assign adc_irq_enable = beep_ctrl_q[`MCCTB_BIT_ADC_IRQ];

   // Time-base counter, stopped only in full halt
   assign tb_end = (tb_cnt_q == tb_period(tb_active_q) - 18'd1);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tb_cnt_q <= 18'h0_0000;
         tb_active_q <= 2'h0;
      end
      else if (mode_q != MCCTB_HALT)
      begin
         if (tb_end)
         begin
            tb_cnt_q <= 18'h0_0000;
            tb_active_q <= timebase_sel_q;
         end
         else
            tb_cnt_q <= tb_cnt_q + 18'd1;
      end
   end

   // Flag: period end sets, a read clears, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timebase_flag_q <= 1'b0;
      else if (tb_end & (mode_q != MCCTB_HALT))
         timebase_flag_q <= 1'b1;
      else if (rd_csr)
         timebase_flag_q <= 1'b0;
   end

   assign timebase_irq = timebase_flag_q & timebase_irq_enable_q;

   // Power mode: halt entry and wake-up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= MCCTB_RUN;
      else
      begin
         case (mode_q)
            MCCTB_RUN:
               if (halt_exec)
                  mode_q <= timebase_irq_enable_q ? MCCTB_ACTIVE_HALT
                     : MCCTB_HALT;
            MCCTB_ACTIVE_HALT:
               if (timebase_irq | wake_irq)
                  mode_q <= MCCTB_RUN;
            MCCTB_HALT:
               if (wake_irq)
                  mode_q <= MCCTB_RUN;
            default:
               mode_q <= MCCTB_RUN;
         endcase
      end
   end

   assign power_mode = mode_q;

   // CPU prescaler and clock-out divider
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_cnt_q <= 4'h0;
         clk_div_q <= 1'b0;
      end
      else
      begin
         pre_cnt_q <= pre_cnt_q + 4'h1;
         clk_div_q <= ~clk_div_q;
      end
   end

   // One tick per CPU clock: every cycle, or every 2..16 in slow mode
   always_comb
   begin
      logic [3:0] mask;
      mask = 4'h0;
      case (cpu_prescale_sel_q)
         2'h0: mask = 4'h1;
         2'h1: mask = 4'h3;
         2'h2: mask = 4'h7;
         default: mask = 4'hf;
      endcase
      if (mode_q != MCCTB_RUN)
         cpu_tick = 1'b0;
      else if (!slow_select_q)
         cpu_tick = 1'b1;
      else
         cpu_tick = ((pre_cnt_q & mask) == mask);
   end

   // Clock-out pin, silenced in halt modes
   assign clock_out_pin = clk_div_q;
   assign clock_out_pin_oe = clock_out_enable_q
      & (mode_q == MCCTB_RUN);

   // Beeper tone generator, running in active halt too
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         beep_cnt_q <= 14'h0000;
         beeper_pin <= 1'b0;
      end
      else if (beep_ctrl_q[1:0] == 2'h0 || mode_q == MCCTB_HALT)
      begin
         beep_cnt_q <= 14'h0000;
         beeper_pin <= 1'b0;
      end
      else if (beep_cnt_q >= beep_half(beep_ctrl_q[1:0]) - 14'd1)
      begin
         beep_cnt_q <= 14'h0000;
         beeper_pin <= ~beeper_pin;
      end
      else
         beep_cnt_q <= beep_cnt_q + 14'd1;
   end

   assign beeper_pin_oe = (beep_ctrl_q[1:0] != 2'h0);

   // Checks
   AST_CLKOUT_ON: assert property (@(posedge pclk) disable iff (!presetn)
      clock_out_pin_oe |-> clock_out_enable_q)
      else $error("clock out without enable");
   AST_CLKOUT_AHALT: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == MCCTB_ACTIVE_HALT |-> !clock_out_pin_oe)
      else $error("clock out in active halt");
   AST_SLOW_DIV2: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == MCCTB_RUN && slow_select_q && cpu_prescale_sel_q == 2'h0
      && cpu_tick && !(wr_ok && sel_csr)) |=> !cpu_tick)
      else $error("divide by two wrong");
   AST_NORMAL_TICK: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == MCCTB_RUN && !slow_select_q) |-> cpu_tick)
      else $error("normal mode tick missing");
   AST_TB_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      (tb_end && mode_q != MCCTB_HALT) |=> tb_cnt_q == 18'h0_0000
      && tb_active_q == $past(timebase_sel_q))
      else $error("time base wrap wrong");
   AST_TB_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !tb_end |=> $stable(tb_active_q))
      else $error("time base changed mid period");
   AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (tb_end && mode_q != MCCTB_HALT) |=> timebase_flag_q)
      else $error("flag not set");
   AST_FLAG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_csr && !tb_end) |=> !timebase_flag_q)
      else $error("flag not cleared by read");
   AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_csr && !tb_end) |=> !timebase_irq)
      else $error("irq not dropped after read");
   AST_HALT_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == MCCTB_RUN && halt_exec) |=> mode_q ==
      ($past(timebase_irq_enable_q) ? MCCTB_ACTIVE_HALT : MCCTB_HALT))
      else $error("halt entry wrong");
   AST_HALT_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == MCCTB_HALT) |=> $stable(tb_cnt_q)
      && $stable(beep_ctrl_q))
      else $error("halt not frozen");
   AST_AHALT_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == MCCTB_ACTIVE_HALT && !tb_end) |=> tb_cnt_q ==
      $past(tb_cnt_q) + 18'd1)
      else $error("active halt not counting");
endmodule

// *** verif/main_clock_ctrl_rtc_beeper_tb.sv ***
// Self-checking bench of the clock/time-base unit, driven over APB.
// Assumes pclk is the oscillator-derived clock and no other master.
module main_clock_ctrl_rtc_beeper_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [11:0] a;
      logic [31:0] wd;
      logic [31:0] rexp;
      logic rerr;
      logic [3:0] pins;
   } mcctb_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic halt_exec, wake_irq, cpu_tick, clock_out_pin, clock_out_pin_oe;
   logic beeper_pin, beeper_pin_oe, timebase_irq, adc_sample_stretch;
   logic adc_irq_enable;
   logic [1:0] power_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic beep_prev = 1'b0;
   logic irq_prev = 1'b0;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   int gap = 0;
   int last_gap = 0;
   int tog = 0;
   int irqs = 0;
   int irq_t = 0;
   int t0, n;
   // Write, read back, expected error, pins {clkout, stretch, adc irq, beep}
   mcctb_row_t rows [5] = '{
      '{12'h0b0, 32'h80, 32'h80, 1'b0, 4'h8},
      '{12'h0b0, 32'h01, 32'h00, 1'b0, 4'h0},
      '{12'h0b4, 32'h0c, 32'h0c, 1'b0, 4'h6},
      '{12'h0b4, 32'h01, 32'h01, 1'b0, 4'h1},
      '{12'h0b8, 32'hff, 32'h00, 1'b1, 4'h1}};

   // Clock source
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   mcctb_top mcctb_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .halt_exec, .wake_irq,
      .cpu_tick, .clock_out_pin, .clock_out_pin_oe, .beeper_pin,
      .beeper_pin_oe, .timebase_irq, .adc_sample_stretch, .adc_irq_enable,
      .power_mode);

   // Cycle count, beeper edge gaps, interrupt rises and the hang limit
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      gap <= (beeper_pin != beep_prev) ? 1 : gap + 1;
      if (beeper_pin != beep_prev)
      begin
         last_gap <= gap;
         tog <= tog + 1;
      end
      beep_prev <= beeper_pin;
      if (timebase_irq && !irq_prev)
      begin
         irqs <= irqs + 1;
         irq_t <= cyc;
      end
      irq_prev <= timebase_irq;
      if (cyc == 100000)
      begin
         mismatches++;
         complete_run();
      end
   end

   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One-cycle pulse on halt or wake, then let the mode settle
   task automatic hit(input logic wake);
      @(posedge pclk);
      if (wake)
         wake_irq <= 1'b1;
      else
         halt_exec <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
      halt_exec <= 1'b0;
      repeat (3) @(negedge pclk);
   endtask

   task automatic wait_irq();
      n = irqs;
      while (irqs == n)
         @(posedge pclk);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, halt_exec, wake_irq} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h0b0, 32'h0);
      check(rd, 32'h0, "ctrl reset");
      apb(1'b0, 12'h0b4, 32'h0);
      check(rd, 32'h0, "beep reset");
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].wd);
         apb(1'b0, rows[i].a, 32'h0);
         check(rd, rows[i].rexp, "readback");
         check(32'(err), 32'(rows[i].rerr), "slave error");
         check({clock_out_pin_oe, adc_sample_stretch, adc_irq_enable,
            beeper_pin_oe}, 32'(rows[i].pins), "pins");
      end
      $display("test registers done");
      for (int ps = 0; ps < 5; ps++)
      begin
         apb(1'b1, 12'h0b0, (ps < 4) ? 32'h10 | (ps << 5) : 32'h0);
         n = 0;
         repeat (64)
         begin
            @(negedge pclk);
            if (cpu_tick === 1'b1)
               n++;
         end
         check(n, (ps < 4) ? 64 >> (ps + 1) : 64, "ticks");
      end
      @(negedge pclk);
      t0 = clock_out_pin;
      @(negedge pclk);
      check(32'(clock_out_pin), 32'(!t0), "clock out");
      $display("test prescaler done");
      for (int b = 1; b < 3; b++)
      begin
         apb(1'b1, 12'h0b4, b);
         n = tog;
         while (tog < n + 2)
            @(posedge pclk);
         check(last_gap, 2000 << (b - 1), "beep half");
      end
      apb(1'b1, 12'h0b4, 32'h3);
      $display("test beeper done");
      apb(1'b1, 12'h0b0, 32'h02);
      apb(1'b0, 12'h0b0, 32'h0);
      wait_irq();
      t0 = irq_t;
      apb(1'b0, 12'h0b0, 32'h0);
      check(rd, 32'h03, "flag");
      @(negedge pclk);
      check(timebase_irq, 32'h0, "irq cleared");
      apb(1'b1, 12'h0b0, 32'h86);
      hit(1'b0);
      check(power_mode, 32'h1, "active halt");
      check({clock_out_pin_oe, beeper_pin_oe}, 32'h1, "halt pins");
      apb(1'b1, 12'h0b0, 32'h0);
      wait_irq();
      check(irq_t - t0, 32'd16000, "old period");
      t0 = irq_t;
      repeat (4) @(negedge pclk);
      check(power_mode, 32'h0, "woken");
      apb(1'b0, 12'h0b0, 32'h0);
      check(rd, 32'h87, "frozen regs");
      wait_irq();
      check(irq_t - t0, 32'd32000, "new period");
      check(last_gap, 32'd8000, "low tone");
      $display("test time base done");
      apb(1'b0, 12'h0b0, 32'h0);
      apb(1'b1, 12'h0b0, 32'h0);
      hit(1'b0);
      check({power_mode, cpu_tick}, 32'h4, "full halt");
      apb(1'b1, 12'h0b0, 32'h80);
      hit(1'b1);
      check(power_mode, 32'h0, "halt exit");
      apb(1'b0, 12'h0b0, 32'h0);
      check(rd, 32'h0, "halt frozen");
      $display("test halt done");
      apb(1'b1, 12'h0b0, 32'h96);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h0b0, 32'h0);
      check(rd, 32'h0, "ctrl after reset");
      apb(1'b0, 12'h0b4, 32'h0);
      check(rd, 32'h0, "beep after reset");
      check(32'(clock_out_pin_oe), 32'h0, "pin after reset");
      $display("test reset done");
      complete_run();
   end
endmodule
